// ==== hw/bsp_port.sv ====
// Two-word burst SRAM port with double-rate data pins
`include "bsp_defines.svh"
`default_nettype none
module bsp_port (
  input wire logic clock,
  input wire logic nrst,
  input wire logic kPos,
  input wire logic kNeg,
  input wire logic loadStrobeN,
  input wire logic rwSel,
  input wire bsp_pkg::bsp_addr_type addr,
  input wire bsp_pkg::bsp_lane_type byteLaneSelN,
  input wire logic narrowMode,
  input wire bsp_pkg::bsp_word_type dqIn,
  output var bsp_pkg::bsp_word_type dqOut,
  output var logic dqOe
);
  import bsp_pkg::*;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  logic [1:0] kS1_r, kS2_r, kPrev_r, rdPipe_r;
  logic ldS1_r, ldS2_r;
  logic [`BSP_SYNC_W-1:0] datS1_r, datS2_r;
  logic rwS, narS, kRise, kbRise, cmdRead, cmdWrite;
  logic rdHalf_r, wrPend_r, heldValid_r, wrHalf_r, commitStart;
  logic fifoInValid, fifoInReady, fifoOutValid, fifoOutReady, memWe;
  logic hit0, hit1;
  logic [`BSP_ENTRY_W-1:0] fifoInData, fifoOutData;
  logic [`BSP_WADDR_W-1:0] drAddr, rdWa0, rdWa1;
  bsp_addr_type addrS, cAddr_r;
  bsp_addr_type rdAddr0_r, rdAddr1_r, rdCur_r, wrAddrP_r, heldAddr_r;
  bsp_lane_type selS, laneEn, drMask;
  bsp_lane_type heldMask0_r, heldMask1_r, cMask0_r, cMask1_r;
  bsp_word_type dinS, heldData0_r, heldData1_r, cData0_r, cData1_r;
  bsp_word_type drData, memOld, mergedWr, memRd0, memRd1, fwd0, fwd1;
  bsp_word_type mem [`BSP_WORDS];
  bsp_commit_type commitSt_r;

  // Pin synchronisers, clocks and strobe parked high
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      kS1_r <= `BSP_K_RST;
      kS2_r <= `BSP_K_RST;
      kPrev_r <= `BSP_K_RST;
      ldS1_r <= `BSP_LD_RST;
      ldS2_r <= `BSP_LD_RST;
      datS1_r <= `BSP_SYNC_RST;
      datS2_r <= `BSP_SYNC_RST;
    end
    else
    begin
      kS1_r <= {kPos, kNeg};
      kS2_r <= kS1_r;
      kPrev_r <= kS2_r;
      ldS1_r <= loadStrobeN;
      ldS2_r <= ldS1_r;
      datS1_r <= {rwSel, narrowMode, addr, byteLaneSelN, dqIn};
      datS2_r <= datS1_r;
    end
  end

  assign {rwS, narS, addrS, selS, dinS} = datS2_r;
  assign kRise = kS2_r[1] & ~kPrev_r[1];
  assign kbRise = kS2_r[0] & ~kPrev_r[0];
  assign cmdRead = kRise & ~ldS2_r & rwS;
  assign cmdWrite = kRise & ~ldS2_r & ~rwS;
  assign laneEn = narS ? (~selS & `BSP_NARROW_MASK) : ~selS;

  // Command pipeline
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      rdPipe_r <= 2'h0;
      rdAddr0_r <= '0;
      rdAddr1_r <= '0;
      wrPend_r <= 1'b0;
      wrAddrP_r <= '0;
    end
    else if (kRise)
    begin
      rdPipe_r <= {rdPipe_r[0], cmdRead};
      rdAddr0_r <= addrS;
      rdAddr1_r <= rdAddr0_r;
      wrPend_r <= cmdWrite;
      if (cmdWrite)
        wrAddrP_r <= addrS;
    end
  end

  // Write data capture into the held registers
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      heldAddr_r <= '0;
      heldData0_r <= '0;
      heldData1_r <= '0;
      heldMask0_r <= '0;
      heldMask1_r <= '0;
      heldValid_r <= 1'b0;
      wrHalf_r <= 1'b0;
    end
    else if (kRise && wrPend_r)
    begin
      heldAddr_r <= wrAddrP_r;
      heldData0_r <= dinS;
      heldMask0_r <= laneEn;
      heldValid_r <= 1'b0;
      wrHalf_r <= 1'b1;
    end
    else if (kbRise && wrHalf_r)
    begin
      heldData1_r <= dinS;
      heldMask1_r <= laneEn;
      heldValid_r <= 1'b1;
      wrHalf_r <= 1'b0;
    end
  end

  // Next write's first word commits the posted write
  assign commitStart = kRise && wrPend_r && heldValid_r;

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      commitSt_r <= COMMIT_IDLE;
    else
    begin
      case (commitSt_r)
        COMMIT_IDLE:
          if (commitStart)
            commitSt_r <= COMMIT_W0;
        COMMIT_W0:
          if (fifoInReady)
            commitSt_r <= COMMIT_W1;
        COMMIT_W1:
          if (fifoInReady)
            commitSt_r <= COMMIT_IDLE;
        default:
          commitSt_r <= COMMIT_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      cAddr_r <= '0;
      cData0_r <= '0;
      cData1_r <= '0;
      cMask0_r <= '0;
      cMask1_r <= '0;
    end
    else if (commitStart && commitSt_r == COMMIT_IDLE)
    begin
      cAddr_r <= heldAddr_r;
      cData0_r <= heldData0_r;
      cData1_r <= heldData1_r;
      cMask0_r <= heldMask0_r;
      cMask1_r <= heldMask1_r;
    end
  end

  // Word A then word A+1 into the FIFO
  assign fifoInValid = commitSt_r != COMMIT_IDLE;
  assign fifoInData = (commitSt_r == COMMIT_W1) ?
    {cAddr_r, 1'b1, cMask1_r, cData1_r} :
    {cAddr_r, 1'b0, cMask0_r, cData0_r};

  bsp_fifo #(
    .WIDTH(`BSP_ENTRY_W),
    .DEPTH(`BSP_FIFO_DEPTH)
  ) bsp_fifo_i (
    .clock(clock),
    .nrst(nrst),
    .inValid(fifoInValid),
    .inReady(fifoInReady),
    .inData(fifoInData),
    .outValid(fifoOutValid),
    .outReady(fifoOutReady),
    .outData(fifoOutData)
  );

  // Drain stalls on clock-edge cycles when reads use the array
  assign fifoOutReady = ~(kRise | kbRise);
  assign memWe = fifoOutValid & fifoOutReady;
  assign {drAddr, drMask, drData} = fifoOutData;
  assign memOld = mem[drAddr];
  assign rdWa0 = {rdAddr1_r, 1'b0};
  assign rdWa1 = {rdCur_r, 1'b1};
  assign memRd0 = mem[rdWa0];
  assign memRd1 = mem[rdWa1];
  assign hit0 = heldValid_r && rdAddr1_r == heldAddr_r;
  assign hit1 = heldValid_r && rdCur_r == heldAddr_r;

  // Per-lane merge for writes and forwarding
  genvar l;
  for (l = 0; l < `BSP_LANES; l++)
  begin : g_lane
    localparam int LO = l * `BSP_LANE_W;
    assign mergedWr[LO +: `BSP_LANE_W] = drMask[l] ?
      drData[LO +: `BSP_LANE_W] :
      memOld[LO +: `BSP_LANE_W];
    assign fwd0[LO +: `BSP_LANE_W] = (hit0 && heldMask0_r[l]) ?
      heldData0_r[LO +: `BSP_LANE_W] :
      memRd0[LO +: `BSP_LANE_W];
    assign fwd1[LO +: `BSP_LANE_W] = (hit1 && heldMask1_r[l]) ?
      heldData1_r[LO +: `BSP_LANE_W] :
      memRd1[LO +: `BSP_LANE_W];
  end

  always_ff @(posedge clock)
  begin
    if (memWe)
      mem[drAddr] <= mergedWr;
  end

  // Read launch on both clock rises
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      dqOut <= '0;
      dqOe <= 1'b0;
      rdHalf_r <= 1'b0;
      rdCur_r <= '0;
    end
    else if (kRise)
    begin
      if (rdPipe_r[1])
      begin
        dqOut <= fwd0;
        dqOe <= 1'b1;
        rdHalf_r <= 1'b1;
        rdCur_r <= rdAddr1_r;
      end
      else
      begin
        dqOe <= 1'b0;
        rdHalf_r <= 1'b0;
      end
    end
    else if (kbRise && rdHalf_r)
    begin
      dqOut <= fwd1;
      rdHalf_r <= 1'b0;
    end
  end

  AST_CMD_IGNORED: assert property (
    kRise && ldS2_r |=> !rdPipe_r[0] && !wrPend_r)
    else $error("deselected cycle started an operation");
  AST_READ_WORD0: assert property (
    kRise && rdPipe_r[1] |=> dqOe && rdHalf_r && dqOut == $past(fwd0))
    else $error("first read word not launched");
  AST_READ_WORD1: assert property (
    kbRise && !kRise && rdHalf_r |=> dqOe && dqOut == $past(fwd1))
    else $error("second read word not launched");
  AST_BURST_NEXT: assert property (
    kbRise && !kRise && rdHalf_r && !hit1 |=> dqOut == $past(memRd1))
    else $error("second word not from next location");
  AST_FLOAT_AFTER: assert property (
    kRise && !rdPipe_r[1] |=> !dqOe ##1 (dqOe || !rdHalf_r))
    else $error("pins not floated after read");
  AST_IDLE_FLOAT: assert property (
    !dqOe && !(kRise && rdPipe_r[1]) |=> !dqOe)
    else $error("pins driven without a read");
  AST_STANDBY: assert property (
    !kRise && !kbRise |=> $stable(dqOut) && $stable(dqOe)
      && $stable(rdPipe_r) && $stable(wrPend_r))
    else $error("state moved while clocks stopped");
  AST_WR_WORD0: assert property (
    kRise && wrPend_r |=> heldData0_r == $past(dinS)
      && heldAddr_r == $past(wrAddrP_r) && wrHalf_r)
    else $error("first write word not captured");
  AST_WR_WORD1: assert property (
    kbRise && !kRise && wrHalf_r |=> heldValid_r
      && heldMask1_r == $past(laneEn) && heldData1_r == $past(dinS))
    else $error("second write half not captured");
  AST_NARROW: assert property (
    kRise && wrPend_r && narS |=> heldMask0_r[3:2] == 2'h0)
    else $error("narrow mode wrote upper lanes");
  AST_LANE_KEEP: assert property (
    memWe && drMask == '0 |-> mergedWr == memOld)
    else $error("masked half altered the array");
  AST_LANE_ALL: assert property (
    memWe && &drMask |-> mergedWr == drData)
    else $error("full write lost bits");
  AST_LANE_ONE: assert property (
    memWe && !drMask[0] |-> mergedWr[8:0] == memOld[8:0])
    else $error("lane 0 altered without select");
  AST_POSTED: assert property (
    heldValid_r && !(kRise && wrPend_r) |=> heldValid_r
      && $stable(heldAddr_r) && $stable(heldData1_r))
    else $error("posted write lost before next write");
  AST_COMMIT: assert property (
    commitStart && commitSt_r == COMMIT_IDLE |=> commitSt_r == COMMIT_W0
      && cAddr_r == $past(heldAddr_r))
    else $error("posted write not committed");

  COV_READ: cover property (kRise && rdPipe_r[1] ##[1:40] kbRise && rdHalf_r);
  COV_WRITE: cover property (kbRise && wrHalf_r);
  COV_FORWARD: cover property (kRise && rdPipe_r[1] && hit0);
  COV_MASKED: cover property (memWe && drMask != '0 && !(&drMask));
endmodule : bsp_port
`default_nettype wire

// ==== hw/bsp_defines.svh ====
// Constants of the two-word burst SRAM port
`ifndef BSP_DEFINES_SVH
`define BSP_DEFINES_SVH
`define BSP_DATA_W 36
`define BSP_LANE_W 9
`define BSP_LANES 4
`define BSP_NARROW_MASK 4'h3
`define BSP_ADDR_W 6
`define BSP_WADDR_W 7
`define BSP_WORDS 128
`define BSP_ENTRY_W 47
`define BSP_FIFO_DEPTH 4
`define BSP_SYNC_W 48
`define BSP_K_RST 2'h3
`define BSP_LD_RST 1'h1
`define BSP_SYNC_RST 48'h0
`endif

// ==== hw/bsp_pkg.sv ====
// Types of the two-word burst SRAM port
`include "bsp_defines.svh"
`default_nettype none
package bsp_pkg;
  typedef logic [`BSP_DATA_W-1:0] bsp_word_type;
  typedef logic [`BSP_ADDR_W-1:0] bsp_addr_type;
  typedef logic [`BSP_LANES-1:0] bsp_lane_type;
  typedef enum logic [2:0] {
    COMMIT_IDLE = 3'h1,
    COMMIT_W0 = 3'h2,
    COMMIT_W1 = 3'h4
  } bsp_commit_type;
endpackage : bsp_pkg
`default_nettype wire

// ==== hw/bsp_fifo.sv ====
// Posted-write FIFO between the pin side and the array
`default_nettype none
module bsp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] FULLCNT = (PW + 1)'(DEPTH);
  localparam logic [PW-1:0] LASTPTR = PW'(DEPTH - 1);
  logic [WIDTH-1:0] store [DEPTH];
  logic [PW-1:0] wrPtr_r;
  logic [PW-1:0] rdPtr_r;
  logic [PW:0] count_r;
  logic push;
  logic pop;

  assign inReady = count_r != FULLCNT;
  assign outValid = count_r != '0;
  assign outData = store[rdPtr_r];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_ff @(posedge clock)
  begin
    if (push)
      store[wrPtr_r] <= inData;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end
    else
    begin
      if (push)
        wrPtr_r <= (wrPtr_r == LASTPTR) ? '0 : wrPtr_r + 1'b1;
      if (pop)
        rdPtr_r <= (rdPtr_r == LASTPTR) ? '0 : rdPtr_r + 1'b1;
      if (push && !pop)
        count_r <= count_r + 1'b1;
      else if (pop && !push)
        count_r <= count_r - 1'b1;
    end
  end

  AST_FIFO_NO_OVER: assert property (@(posedge clock) disable iff (!nrst)
    count_r == FULLCNT |-> !inReady)
    else $error("fifo full but ready");
endmodule : bsp_fifo
`default_nettype wire

// ==== tb/bsp_ctrl_model.sv ====
// Controller model driving the burst SRAM port pins
`default_nettype none
module bsp_ctrl_model import bsp_pkg::*; (
  input wire logic clock,
  output logic kPos,
  output logic kNeg,
  output logic loadStrobeN,
  output logic rwSel,
  output var bsp_pkg::bsp_addr_type addr,
  output var bsp_pkg::bsp_lane_type byteLaneSelN,
  output var bsp_pkg::bsp_word_type dqIn,
  input wire bsp_pkg::bsp_word_type dqOut,
  input wire logic dqOe
);
  timeunit 1ns;
  timeprecision 1ns;
  bsp_word_type drv;
  logic drvEn;
  bsp_word_type qFirst;
  bsp_word_type qSecond;
  logic oeFirst;
  logic oeSecond;
  // Wire level: device, controller, else inverse of last value
  assign dqIn = dqOe ? dqOut : (drvEn ? drv : ~drv);
  initial
  begin
    kPos = 1'h1;
    kNeg = 1'h1;
    loadStrobeN = 1'h1;
    rwSel = 1'h0;
    addr = 6'h00;
    byteLaneSelN = 4'hf;
    drv = 36'h0;
    drvEn = 1'h0;
  end
  // One K period of 8 clocks: K rise at 2, K# rise at 5
  task automatic cyc(input logic ld, input logic rw, input bsp_addr_type a,
    input logic wr, input bsp_word_type d0, input bsp_lane_type l0,
    input bsp_word_type d1, input bsp_lane_type l1);
    @(negedge clock);
    kPos = 1'h0;
    loadStrobeN = ld;
    rwSel = rw;
    addr = a;
    drvEn = wr;
    drv = d0;
    byteLaneSelN = l0;
    repeat (2) @(negedge clock);
    qSecond = dqOut;
    oeSecond = dqOe;
    kPos = 1'h1;
    kNeg = 1'h0;
    repeat (2) @(negedge clock);
    drv = d1;
    byteLaneSelN = l1;
    @(negedge clock);
    kNeg = 1'h1;
    repeat (2) @(negedge clock);
    qFirst = dqOut;
    oeFirst = dqOe;
  endtask : cyc
  // Both clocks parked high, a write request left on the pins
  task automatic park(input int n);
    kPos = 1'h1;
    kNeg = 1'h1;
    loadStrobeN = 1'h0;
    rwSel = 1'h0;
    repeat (n) @(negedge clock);
  endtask : park
endmodule : bsp_ctrl_model
`default_nettype wire

// ==== tb/tb_bsp_port.sv ====
// Self-checking bench of the two-word burst SRAM port
`default_nettype none
module tb_bsp_port import bsp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'h0;
  logic nrst = 1'h0;
  logic narrowMode = 1'h0;
  logic kPos, kNeg, loadStrobeN, rwSel, dqOe;
  bsp_addr_type addr;
  bsp_lane_type byteLaneSelN;
  bsp_word_type dqIn, dqOut;
  int miscompares = 0;
  int cmp_count = 0;
  int nOps = 0;
  int kind [64];
  bsp_addr_type opA [64];
  bsp_word_type d0 [64], d1 [64], e0 [64], e1 [64];
  bsp_lane_type l0 [64], l1 [64];
  bsp_word_type mem [128];
  always #5 clock = ~clock;
  bsp_port bsp_port_i (.clock(clock), .nrst(nrst), .kPos(kPos), .kNeg(kNeg),
    .loadStrobeN(loadStrobeN), .rwSel(rwSel), .addr(addr),
    .byteLaneSelN(byteLaneSelN), .narrowMode(narrowMode), .dqIn(dqIn),
    .dqOut(dqOut), .dqOe(dqOe));
  bsp_ctrl_model bsp_ctrl_model_i (.clock(clock), .kPos(kPos), .kNeg(kNeg),
    .loadStrobeN(loadStrobeN), .rwSel(rwSel), .addr(addr),
    .byteLaneSelN(byteLaneSelN), .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe));
  task automatic chk(input string what, input bsp_word_type seen,
    input bsp_word_type exp);
    cmp_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  function automatic bsp_word_type pat(input int i);
    return {i[7:0], ~i[7:0], i[7:0] ^ 8'h5a, i[7:0] + 8'h33, i[3:0]};
  endfunction : pat
  // Expected array word after one masked half
  function automatic bsp_word_type merge(input bsp_word_type o,
    input bsp_word_type n, input bsp_lane_type l);
    bsp_lane_type m;
    m = narrowMode ? (l | 4'hc) : l;
    for (int k = 0; k < 4; k++)
      if (!m[k])
        o[9*k +: 9] = n[9*k +: 9];
    return o;
  endfunction : merge
  task automatic addW(input int a, input bsp_word_type x0,
    input bsp_lane_type m0, input bsp_word_type x1, input bsp_lane_type m1);
    kind[nOps] = 1;
    opA[nOps] = a[5:0];
    d0[nOps] = x0;
    d1[nOps] = x1;
    l0[nOps] = m0;
    l1[nOps] = m1;
    mem[{a[5:0], 1'h0}] = merge(mem[{a[5:0], 1'h0}], x0, m0);
    mem[{a[5:0], 1'h1}] = merge(mem[{a[5:0], 1'h1}], x1, m1);
    nOps++;
  endtask : addW
  task automatic addR(input int a);
    kind[nOps] = 2;
    opA[nOps] = a[5:0];
    e0[nOps] = mem[{a[5:0], 1'h0}];
    e1[nOps] = mem[{a[5:0], 1'h1}];
    nOps++;
  endtask : addR
  // Runs the op list, write data one K period after its command
  task automatic play();
    int k;
    int p;
    logic wr;
    for (int i = 0; i < nOps + 3; i++)
    begin
      k = (i < nOps) ? kind[i] : 0;
      p = (i > 0) ? i - 1 : 0;
      wr = (i > 0) && (kind[p] == 1);
      bsp_ctrl_model_i.cyc(k == 0, (k == 0) ? i[0] : k == 2,
        (k == 0) ? i[5:0] : opA[i], wr, d0[p], wr ? l0[p] : 4'h0, d1[p],
        wr ? l1[p] : 4'h0);
      if (i >= 2 && kind[i-2] == 2)
      begin
        chk("oe first", 36'(bsp_ctrl_model_i.oeFirst), 36'h1);
        chk("word A", bsp_ctrl_model_i.qFirst, e0[i-2]);
      end
      else
        chk("oe idle", 36'(bsp_ctrl_model_i.oeFirst), 36'h0);
      if (i >= 3 && kind[i-3] == 2)
      begin
        chk("oe second", 36'(bsp_ctrl_model_i.oeSecond), 36'h1);
        chk("word A+1", bsp_ctrl_model_i.qSecond, e1[i-3]);
      end
    end
    for (int i = 0; i < 64; i++)
      kind[i] = 0;
    nOps = 0;
  endtask : play
  task automatic test_reset();
    chk("oe reset", 36'(dqOe), 36'h0);
    for (int i = 0; i < 3; i++)
      kind[i] = 0;
    nOps = 3;
    play();
    $display("test reset done");
  endtask : test_reset
  task automatic test_burst();
    for (int a = 0; a < 4; a++)
      addW(a, pat(a), 4'h0, pat(a + 100), 4'h0);
    for (int a = 0; a < 4; a++)
      addR(a);
    nOps += 2;
    addW(4, pat(9), 4'h0, pat(8), 4'h0);
    nOps++;
    addR(4);
    play();
    $display("test burst done");
  endtask : test_burst
  task automatic test_lanes();
    for (int i = 0; i < 16; i++)
      addW(16 + i, pat(i + 50), 4'h0, pat(i + 60), 4'h0);
    for (int i = 0; i < 16; i++)
      addW(16 + i, ~pat(i), i[3:0], pat(i + 7), ~i[3:0]);
    for (int i = 0; i < 16; i++)
      addR(16 + i);
    play();
    $display("test lanes done");
  endtask : test_lanes
  task automatic test_stop();
    bsp_ctrl_model_i.cyc(1'h0, 1'h1, 6'h01, 1'h0, 36'h0, 4'h0, 36'h0, 4'h0);
    bsp_ctrl_model_i.cyc(1'h1, 1'h0, 6'h02, 1'h0, 36'h0, 4'h0, 36'h0, 4'h0);
    bsp_ctrl_model_i.park(20);
    bsp_ctrl_model_i.cyc(1'h1, 1'h0, 6'h02, 1'h0, 36'h0, 4'h0, 36'h0, 4'h0);
    chk("stop A", bsp_ctrl_model_i.qFirst, mem[7'h02]);
    bsp_ctrl_model_i.park(20);
    chk("stop drive", 36'(dqOe), 36'h1);
    chk("stop word", dqOut, mem[7'h03]);
    bsp_ctrl_model_i.cyc(1'h1, 1'h0, 6'h02, 1'h0, 36'h0, 4'h0, 36'h0, 4'h0);
    chk("stop A+1", bsp_ctrl_model_i.qSecond, mem[7'h03]);
    bsp_ctrl_model_i.park(20);
    chk("stop hold", dqOut, mem[7'h03]);
    chk("stop oe", 36'(dqOe), 36'h0);
    $display("test stop done");
  endtask : test_stop
  task automatic test_narrow();
    for (int i = 0; i < 4; i++)
      addW(40 + i, pat(i + 80), 4'h0, pat(i + 90), 4'h0);
    addW(63, pat(1), 4'h0, pat(2), 4'h0);
    play();
    @(negedge clock);
    narrowMode = 1'h1;
    for (int i = 0; i < 4; i++)
      addW(40 + i, ~pat(i), i[3:0], pat(i + 3), 4'h3 - i[3:0]);
    for (int i = 0; i < 4; i++)
      addR(40 + i);
    play();
    $display("test narrow done");
  endtask : test_narrow
  task automatic results();
    $display("Comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : results
  initial
  begin
    #500000;
    miscompares++;
    results();
  end
  initial
  begin
    repeat (5) @(negedge clock);
    nrst = 1'h1;
    repeat (4) @(negedge clock);
    test_reset();
    test_burst();
    test_lanes();
    test_stop();
    test_narrow();
    results();
  end
endmodule : tb_bsp_port
`default_nettype wire
